// File: logic/wdt_pkg.sv
// watchdog package: register map, field positions, codes and reset values
// assumes a 32-bit apb slave with byte addresses, one register per aligned word
package wdt_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] CODE_OFFSET = 12'h004;
    localparam logic [11:0] COUNT_OFFSET = 12'h008;
    localparam logic [11:0] STATUS_OFFSET = 12'h00c;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int ACTION_BIT = 0;
    localparam int PERIOD_LSB = 1;
    localparam int WINDOW_LSB = 4;
    localparam int RUN_ENABLE_BIT = 7;
    localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbf;
    localparam logic [7:0] CONTROL_RESET = 8'h80;

    // ----------------------------------------
    // status register fields
    // ----------------------------------------
    localparam int OPERATING_BIT = 0;
    localparam int EARLY_CLEAR_BIT = 1;
    localparam int OVERFLOW_BIT = 2;
    localparam logic [7:0] STATUS_FIXED = 8'h58;

    // ----------------------------------------
    // control codes and window starts
    // ----------------------------------------
    localparam logic [7:0] CLEAR_CODE = 8'h4e;
    localparam logic [7:0] DISABLE_CODE = 8'hb1;
    localparam logic [1:0] WINDOW_ANY = 2'h0;
    localparam logic [7:0] WINDOW_START_1 = 8'h40;
    localparam logic [7:0] WINDOW_START_2 = 8'h80;
    localparam logic [7:0] WINDOW_START_3 = 8'hc0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // ----------------------------------------
    // source clock prescaler
    // ----------------------------------------
    localparam int PRESCALE_WIDTH = 24;
    localparam int TICK_SHIFT_BASE = 10;
    localparam int TICK_SHIFT_STEP = 2;

endpackage : wdt_pkg

// File: logic/source_tick_gen.sv
// source clock tick generator for the watchdog counter
// assumes clk is the system clock; tick is one clk cycle wide
`timescale 1ns/10ps
`default_nettype none

module source_tick_gen #(
    parameter int SHIFT_BASE = wdt_pkg::TICK_SHIFT_BASE
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] periodSelect,
    output logic tick
);

    // ----------------------------------------
    // free-running prescaler
    // ----------------------------------------
    logic [wdt_pkg::PRESCALE_WIDTH-1:0] prescale_reg;
    logic [wdt_pkg::PRESCALE_WIDTH-1:0] prescale_next;
    logic tick_reg;
    logic tick_next;
    logic [wdt_pkg::PRESCALE_WIDTH-1:0] mask;
    int shift;

    // period doubles twice per select step; runs free of the enable bit
    always_comb begin
        shift = SHIFT_BASE + wdt_pkg::TICK_SHIFT_STEP * int'(periodSelect);
        mask = ~({wdt_pkg::PRESCALE_WIDTH{1'b1}} << shift);
        prescale_next = prescale_reg + 1'b1;
        tick_next = (prescale_reg & mask) == mask;
    end

    // registers only
    always_ff @(posedge clk) begin
        if (reset) begin
            prescale_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            prescale_reg <= prescale_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : source_tick_gen

`default_nettype wire

// File: logic/windowed_watchdog_timer.sv
// windowed watchdog timer with apb register access
// assumes apb master on clk; low-power mode pins are asynchronous and synchronised here
// Operation
// [R01] action select 0: counter overflow raises the watchdog interrupt request
// [R02] action select 1: counter overflow raises the watchdog reset request
// [R03] watchdog interrupt is non-maskable, ignores the master interrupt enable
// [R04] a new watchdog interrupt is taken at once, preempting the one in service
// [R05] watchdog reset request resets the whole device, then warm-up follows
// [R06] clear code zeroes the counter; counting continues afterwards
// [R07] disable code stops the watchdog only when run enable is already 0
// [R08] software must clear before overflow and within the clear window
// [R09] clear write wins over a same-cycle overflow; no overflow detected
// [R10] count monitor read returns the live counter value
// [R11] operating flag reads 1 when enabled, 0 when disabled
// [R12] overflow cause flag sets when overflow raises the interrupt request
// [R13] early-clear cause flag sets when a clear outside the window interrupts
// [R14] any status read clears both interrupt cause flags
// [R15] a cause flag set coinciding with a status read stays set
// [R16] disabling zeroes the counter; setting run enable re-enables without code
// [R17] window select 00 allows clears anytime; else outside clears interrupt only
// [R18] in interrupt mode the counter keeps counting past overflow
// [R19] counter pauses in stop, warm-up, idle and sleep modes, then resumes; here only stopMode and idleMode pause it
// [R20] overflow is the wrap from all ones to zero on a source tick
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module windowed_watchdog_timer #(
    parameter int TICK_SHIFT_BASE = wdt_pkg::TICK_SHIFT_BASE
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stopMode,
    input wire logic idleMode,
    output logic nmiRequest,
    output logic resetRequest
);

    // ----------------------------------------
    // register map and timing
    // ----------------------------------------
    // control, offset 0x000:
    //   bit 0 overflow action, 0 raises the interrupt, 1 the reset request
    //   bits 2:1 overflow period select, four times longer per step
    //   bit 3 writable but unused
    //   bits 5:4 clear window select, 00 lets a clear through at any count
    //   bit 6 reads 0
    //   bit 7 run enable; writing 1 re-enables the watchdog at once
    // code, offset 0x004, write-only and reads 0:
    //   clear code zeroes the count when the count is inside the window
    //   disable code stops the watchdog only with run enable already 0
    // count monitor, offset 0x008: live count in bits 7:0
    // status, offset 0x00c:
    //   bit 0 operating, bit 1 early-clear cause, bit 2 overflow cause
    //   bits 7:3 a fixed pattern; both cause flags clear when read
    // upper 24 bits of every register read as 0
    //
    // bus timing:
    //   every access completes in its first access cycle
    //   read data are taken at the setup edge, so a read shows that edge's value
    //   unmapped offsets answer with pslverr, read 0 and ignore writes
    //
    // limitations:
    //   request pulses last one cycle; the cpu side must latch them
    //   the device reset itself lies outside; only the request leaves here
    //   the watchdog is enabled out of reset; software must disable it
    //   the prescaler runs free of the enable bit, so the first overflow
    //   after enabling may come up to one source tick early
    //   a clear and a cause-flag read land on the access edge, never the setup
    //   a wrap in reset mode leaves the overflow cause flag alone
    //
    // trade-off: read data are registered at setup to keep prdata off the
    // combinational path, at the price of showing a value one cycle old

    // ----------------------------------------
    // low-power mode synchronisers
    // ----------------------------------------
    logic [1:0] stopSync_reg;
    logic [1:0] stopSync_next;
    logic [1:0] idleSync_reg;
    logic [1:0] idleSync_next;
    logic paused;

    // first stage is read only by the second stage
    always_comb begin
        stopSync_next = {stopSync_reg[0], stopMode};
        idleSync_next = {idleSync_reg[0], idleMode};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stopSync_reg <= 2'b00;
            idleSync_reg <= 2'b00;
        end else begin
            stopSync_reg <= stopSync_next;
            idleSync_reg <= idleSync_next;
        end
    end

    assign paused = stopSync_reg[1] | idleSync_reg[1];

    // ----------------------------------------
    // source tick
    // ----------------------------------------
    logic [7:0] control_reg;
    logic tick;

    source_tick_gen #(
        .SHIFT_BASE(TICK_SHIFT_BASE)
    ) u_tick (
        .clk(clk),
        .reset(reset),
        .periodSelect(control_reg[wdt_pkg::PERIOD_LSB +: 2]),
        .tick(tick)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic setupPhase;
    logic accessPhase;
    logic writeAccess;
    logic readAccess;
    logic mapped;

    assign setupPhase = psel & ~penable;
    assign accessPhase = psel & penable;
    assign writeAccess = accessPhase & pwrite;
    assign readAccess = accessPhase & ~pwrite;

    // only the four aligned words answer; everything else errors
    always_comb begin
        unique case (paddr)
            wdt_pkg::CONTROL_OFFSET,
            wdt_pkg::CODE_OFFSET,
            wdt_pkg::COUNT_OFFSET,
            wdt_pkg::STATUS_OFFSET: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states
    assign pready = 1'b1;
    assign pslverr = accessPhase & ~mapped;

    // ----------------------------------------
    // watchdog core
    // ----------------------------------------
    logic [7:0] control_next;
    logic enabled_reg;
    logic enabled_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic overflowFlag_reg;
    logic overflowFlag_next;
    logic earlyFlag_reg;
    logic earlyFlag_next;
    logic nmi_reg;
    logic nmi_next;
    logic resetReq_reg;
    logic resetReq_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic codeWrite;
    logic clearCode;
    logic disableCode;
    logic inWindow;
    logic clearOk;
    logic clearEarly;
    logic overflow;
    logic statusRead;
    logic [7:0] statusValue;

    // window start per select; the count must have reached it
    always_comb begin
        unique case (control_reg[wdt_pkg::WINDOW_LSB +: 2])
            2'h1: inWindow = count_reg >= wdt_pkg::WINDOW_START_1;
            2'h2: inWindow = count_reg >= wdt_pkg::WINDOW_START_2;
            2'h3: inWindow = count_reg >= wdt_pkg::WINDOW_START_3;
            default: inWindow = 1'b1; // R17
        endcase
    end

    assign codeWrite = writeAccess & (paddr == wdt_pkg::CODE_OFFSET);
    assign clearCode = codeWrite & (pwdata[7:0] == wdt_pkg::CLEAR_CODE);
    assign disableCode = codeWrite & (pwdata[7:0] == wdt_pkg::DISABLE_CODE);
    assign clearOk = clearCode & enabled_reg & inWindow; // R17
    assign clearEarly = clearCode & enabled_reg & ~inWindow; // R13
    // a good clear masks the wrap in the same cycle
    assign overflow = enabled_reg & tick & ~paused & (count_reg == wdt_pkg::COUNT_MAX) & ~clearOk; // R20 R09
    assign statusRead = readAccess & (paddr == wdt_pkg::STATUS_OFFSET);

    assign statusValue = wdt_pkg::STATUS_FIXED
        | ({7'h00, overflowFlag_reg} << wdt_pkg::OVERFLOW_BIT)
        | ({7'h00, earlyFlag_reg} << wdt_pkg::EARLY_CLEAR_BIT)
        | ({7'h00, enabled_reg} << wdt_pkg::OPERATING_BIT); // R11

    // next state of control, counter, flags and request pulses
    always_comb begin
        control_next = control_reg;
        enabled_next = enabled_reg;
        count_next = count_reg;
        overflowFlag_next = overflowFlag_reg;
        earlyFlag_next = earlyFlag_reg;
        nmi_next = 1'b0;
        resetReq_next = 1'b0;
        if (writeAccess && paddr == wdt_pkg::CONTROL_OFFSET) begin
            control_next = pwdata[7:0] & wdt_pkg::CONTROL_WRITE_MASK;
            if (pwdata[wdt_pkg::RUN_ENABLE_BIT]) begin
                enabled_next = 1'b1; // R16
            end
        end
        // count holds while paused; wraps freely in interrupt mode
        if (enabled_reg && tick && !paused) begin
            count_next = count_reg + 8'h01; // R19 R18
        end
        if (clearOk) begin
            count_next = wdt_pkg::COUNT_RESET; // R06 R09
        end
        if (disableCode && !control_reg[wdt_pkg::RUN_ENABLE_BIT]) begin
            enabled_next = 1'b0; // R07
            count_next = wdt_pkg::COUNT_RESET; // R16
        end
        if (overflow && !control_reg[wdt_pkg::ACTION_BIT]) begin
            nmi_next = 1'b1; // R01
        end
        if (overflow && control_reg[wdt_pkg::ACTION_BIT]) begin
            resetReq_next = 1'b1; // R02
        end
        if (clearEarly) begin
            nmi_next = 1'b1; // R17
        end
        // clear only what the read reported, so a later set is kept
        if (statusRead) begin
            overflowFlag_next = overflowFlag_reg & ~rdata_reg[wdt_pkg::OVERFLOW_BIT]; // R14
            earlyFlag_next = earlyFlag_reg & ~rdata_reg[wdt_pkg::EARLY_CLEAR_BIT]; // R14
        end
        if (overflow && !control_reg[wdt_pkg::ACTION_BIT]) begin
            overflowFlag_next = 1'b1; // R12 R15
        end
        if (clearEarly) begin
            earlyFlag_next = 1'b1; // R13 R15
        end
    end

    // read data captured in the setup phase, held through access
    always_comb begin
        rdata_next = rdata_reg;
        if (setupPhase) begin
            unique case (paddr)
                wdt_pkg::CONTROL_OFFSET: rdata_next = {24'h000000, control_reg};
                wdt_pkg::COUNT_OFFSET: rdata_next = {24'h000000, count_reg}; // R10
                wdt_pkg::STATUS_OFFSET: rdata_next = {24'h000000, statusValue};
                default: rdata_next = 32'h00000000; // code register is write-only
            endcase
        end
    end

    // registers only
    always_ff @(posedge clk) begin
        if (reset) begin
            control_reg <= wdt_pkg::CONTROL_RESET;
            enabled_reg <= 1'b1;
            count_reg <= wdt_pkg::COUNT_RESET;
            overflowFlag_reg <= 1'b0;
            earlyFlag_reg <= 1'b0;
            nmi_reg <= 1'b0;
            resetReq_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            control_reg <= control_next;
            enabled_reg <= enabled_next;
            count_reg <= count_next;
            overflowFlag_reg <= overflowFlag_next;
            earlyFlag_reg <= earlyFlag_next;
            nmi_reg <= nmi_next;
            resetReq_reg <= resetReq_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // no mask and no in-service gating: the cpu must nest it every time
    assign nmiRequest = nmi_reg; // R03 R04
    // system reset logic turns this into chip reset and warm-up
    assign resetRequest = resetReq_reg; // R05
    assign prdata = rdata_reg;

endmodule : windowed_watchdog_timer

`default_nettype wire

// File: bench/wdt_checker_sva.sv
// concurrent checks on the watchdog top-level ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module wdt_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nmiRequest,
    input wire logic resetRequest
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic mapped;
    // four aligned words from offset zero
    assign mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_slverr_map: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    chk_slverr_idle: assert property (!(psel && penable) |-> !pslverr) else $error("pslverr outside access");
    chk_nmi_pulse: assert property (nmiRequest |=> !nmiRequest) else $error("nmi pulse too long");
    chk_rst_pulse: assert property (resetRequest |=> !resetRequest) else $error("reset pulse too long");
    chk_req_exclusive: assert property (!(nmiRequest && resetRequest)) else $error("both requests");
    chk_status_fixed: assert property (psel && !penable && !pwrite && paddr == wdt_pkg::STATUS_OFFSET
        |=> prdata[7:3] == 5'h0b && prdata[31:8] == 24'h0) else $error("status fixed bits wrong");
    chk_code_zero: assert property (psel && !penable && !pwrite && paddr == wdt_pkg::CODE_OFFSET
        |=> prdata == 32'h0) else $error("code register read not zero");
    chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
endmodule : wdt_checker
bind windowed_watchdog_timer wdt_checker chk_i (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmiRequest(nmiRequest), .resetRequest(resetRequest));
`default_nettype wire

// File: bench/windowed_watchdog_timer_tb_top.sv
// self-checking bench for the windowed watchdog, apb master and event scoreboard
// assumes a fast tick (shift base 1): one count every two clocks
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
    // ----------------------------------------
    // signals, dut and scoreboard
    // ----------------------------------------
    logic clk, reset, psel, penable, pwrite, pready, pslverr;
    logic stopMode, idleMode, nmiRequest, resetRequest;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] rdq[$];
    logic [1:0] evq[$];
    logic [15:0] e;
    logic [7:0] v;
    int err_total, check_count;
    localparam logic [11:0] CTL = wdt_pkg::CONTROL_OFFSET;
    localparam logic [11:0] CODE = wdt_pkg::CODE_OFFSET;
    localparam logic [11:0] CNT = wdt_pkg::COUNT_OFFSET;
    localparam logic [11:0] STS = wdt_pkg::STATUS_OFFSET;
    localparam logic [7:0] ON = wdt_pkg::STATUS_FIXED | 8'h01;
    localparam logic [7:0] CLR = wdt_pkg::CLEAR_CODE;
    localparam logic [7:0] DIS = wdt_pkg::DISABLE_CODE;
    windowed_watchdog_timer #(.TICK_SHIFT_BASE(1)) dut (.clk(clk), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stopMode(stopMode), .idleMode(idleMode),
        .nmiRequest(nmiRequest), .resetRequest(resetRequest));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    task cmp(input string what, input logic [7:0] x, input logic [7:0] y);
        check_count++;
        if (y !== x) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, x, y);
        end
    endtask : cmp
    // one apb transfer; reads note {mask, value} for the monitor
    task apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [7:0] m, input logic er);
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'($urandom()), d};
        psel <= 1'b1;
        penable <= 1'b0;
        if (!w) rdq.push_back({m, d});
        @(posedge clk);
        penable <= 1'b1;
        // wait for the answer; only the bench watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        cmp("pslverr", {7'h0, er}, {7'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d, 8'h00, 1'b0);
    endtask : wr
    task rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
        apb(a, 1'b0, d, m, 1'b0);
    endtask : rd
    // bounded wait for the noted events to appear
    task settle(input int lim);
        int n;
        n = 0;
        while (evq.size() != 0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (evq.size() != 0) begin
            err_total++;
            $display("Error event expected %0d seen 0", evq.size());
            evq.delete();
        end
    endtask : settle
    // monitor: pulses and completed reads take the oldest note
    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready) begin
            e = (rdq.size() != 0) ? rdq.pop_front() : 16'hffff;
            cmp("read data", e[7:0] & e[15:8], prdata[7:0] & e[15:8]);
        end
        if (nmiRequest || resetRequest) begin
            cmp("event", {6'h0, (evq.size() != 0) ? evq.pop_front() : 2'b00}, {6'h0, nmiRequest, resetRequest});
        end
    end
    initial begin
        #200000;
        err_total++;
        $display("Error watchdog expected done seen timeout");
        results();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, stopMode, idleMode} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        check_count = 0;
        void'($urandom(91));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rd(CTL, 8'h80, 8'hff);
        rd(STS, ON, 8'hff);
        rd(CODE, 8'h00, 8'hff);
        apb(12'h010, 1'b0, 8'h00, 8'hff, 1'b1);
        wr(CODE, CLR);
        rd(CNT, 8'h00, 8'hfc);
        evq.push_back(2'b10);
        settle(1200);
        evq.push_back(2'b10);
        settle(1200);
        rd(STS, ON | 8'h04, 8'hff);
        rd(STS, ON, 8'hff);
        // low-power modes hold the count, longer than one overflow period
        for (int m = 0; m < 2; m++) begin
            wr(CODE, CLR);
            idleMode <= (m == 0);
            stopMode <= (m == 1);
            repeat (700) @(posedge clk);
            rd(CNT, 8'h00, 8'he0);
            idleMode <= 1'b0;
            stopMode <= 1'b0;
        end
        wr(CODE, CLR);
        repeat (4) begin
            v = 8'($urandom());
            wr(CODE, (v == CLR || v == DIS) ? 8'h00 : v);
        end
        wr(CTL, 8'h90);
        evq.push_back(2'b10);
        wr(CODE, CLR);
        settle(20);
        rd(STS, ON | 8'h02, 8'hff);
        repeat (200) @(posedge clk);
        wr(CODE, CLR);
        rd(CNT, 8'h00, 8'hfc);
        // later-starting windows: early clear interrupts, a late one clears
        for (int w = 2; w < 4; w++) begin
            wr(CTL, (w == 2) ? 8'ha0 : 8'hb0);
            evq.push_back(2'b10);
            wr(CODE, CLR);
            settle(20);
            rd(STS, ON | 8'h02, 8'hff);
            repeat (400) @(posedge clk);
            wr(CODE, CLR);
            rd(CNT, 8'h00, 8'hfc);
        end
        // period select 01: one count every eight clocks, no overflow yet
        wr(CTL, 8'h82);
        wr(CODE, CLR);
        repeat (700) @(posedge clk);
        rd(CNT, 8'h40, 8'he0);
        wr(CTL, 8'h00);
        rd(STS, ON, 8'hff);
        wr(CODE, DIS);
        rd(STS, wdt_pkg::STATUS_FIXED, 8'hff);
        repeat (700) @(posedge clk);
        rd(CNT, 8'h00, 8'hff);
        wr(CTL, 8'h80);
        rd(STS, ON, 8'hff);
        wr(CODE, DIS);
        rd(STS, ON, 8'hff);
        wr(CTL, 8'h81);
        wr(CODE, CLR);
        evq.push_back(2'b01);
        settle(1200);
        rd(STS, ON, 8'hff);
        results();
    end
endmodule : windowed_watchdog_timer_tb_top
`default_nettype wire
